// ---- design/rut_pkg.sv ----
/*
 * constants, register map and field layout of the reloadable 8-bit up/down timer.
 * assumes one 200 MHz clock; the bus side is an ahb-lite slave with word registers.
 */
package rut_pkg;
    // byte offsets on the bus
    localparam logic [3:0] OFS_MODE   = 4'h0;
    localparam logic [3:0] OFS_COUNT  = 4'h4;
    localparam logic [3:0] OFS_STOP   = 4'h8;
    localparam logic [3:0] OFS_IRQ    = 4'hC;
    // timer_mode fields
    localparam int         MODE_RELOAD_BIT = 7;
    localparam int         MODE_HWDIR_BIT  = 6;
    localparam int         MODE_SWDIR_BIT  = 5;
    localparam logic [7:0] MODE_RSVD_MASK  = 8'h18;
    localparam logic [7:0] MODE_RESET      = 8'h18;
    // module_clock_stop field
    localparam int         STOP_TIMER_BIT  = 1;
    localparam logic [7:0] STOP_RESET      = 8'hFF;
    // irq control register fields, counter reset values and limits
    localparam int         IRQ_FLAG_BIT    = 0;
    localparam int         IRQ_EN_BIT      = 1;
    localparam int         IRQ_EDGE_BIT    = 2;
    localparam logic [7:0] COUNT_RESET     = 8'h00;
    localparam logic [7:0] RELOAD_RESET    = 8'h00;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;
    localparam logic [7:0] COUNT_MIN       = 8'h00;
    // clock select codes
    localparam logic [2:0] CS_DIV8192 = 3'h0;
    localparam logic [2:0] CS_DIV2048 = 3'h1;
    localparam logic [2:0] CS_DIV512  = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV16   = 3'h4;
    localparam logic [2:0] CS_DIV4    = 3'h5;
    localparam logic [2:0] CS_SUB4    = 3'h6;
    localparam logic [2:0] CS_EVENT   = 3'h7;
    // log2 of the system clock divisors and of the subclock divisor
    localparam int DIV8192_LOG = 13;
    localparam int DIV2048_LOG = 11;
    localparam int DIV512_LOG  = 9;
    localparam int DIV64_LOG   = 6;
    localparam int DIV16_LOG   = 4;
    localparam int DIV4_LOG    = 2;
    localparam int SUB_DIV_LOG = 2;
endpackage : rut_pkg

// ---- design/rut_tick_gen.sv ----
/*
 * count-source generator: system clock prescaler taps, subclock divided by four
 * and edge-detected event pin; one-cycle tick per source, indexed by select code.
 * assumes subclock and event pin are slow compared with core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rut_tick_gen (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // pins and event edge select
    input  wire logic       subclk,
    input  wire logic       event_input_pin,
    input  wire logic       line1_edge_select,
    // ticks by select code
    output logic      [7:0] src_tick
);
    logic [rut_pkg::DIV8192_LOG-1:0] presc;
    logic [1:0]                      sub_sync;
    logic [1:0]                      evt_sync;
    logic                            sub_last;
    logic                            evt_last;
    logic [rut_pkg::SUB_DIV_LOG-1:0] sub_div;

    function automatic logic tap(input logic [rut_pkg::DIV8192_LOG-1:0] c, input int bits);
        logic [rut_pkg::DIV8192_LOG-1:0] m;
        m = rut_pkg::DIV8192_LOG'((1 << bits) - 1);
        return (c & m) == m;
    endfunction : tap

    always_ff @(posedge core_clk) begin
        if (rst) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sub_sync <= 2'h0;
            evt_sync <= 2'h0;
            sub_last <= 1'b0;
            evt_last <= 1'b0;
        end else begin
            sub_sync <= {sub_sync[0], subclk};
            evt_sync <= {evt_sync[0], event_input_pin};
            sub_last <= sub_sync[1];
            evt_last <= evt_sync[1];
        end
    end

    logic sub_rise;
    logic evt_edge;
    assign sub_rise = sub_sync[1] && !sub_last;
    // edge select high counts rising edges, low counts falling edges
    assign evt_edge = line1_edge_select ? (evt_sync[1] && !evt_last)
                                        : (!evt_sync[1] && evt_last);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sub_div <= '0;
        end else if (sub_rise) begin
            sub_div <= sub_div + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            src_tick <= 8'h00;
        end else begin
            src_tick[rut_pkg::CS_DIV8192] <= tap(presc, rut_pkg::DIV8192_LOG);
            src_tick[rut_pkg::CS_DIV2048] <= tap(presc, rut_pkg::DIV2048_LOG);
            src_tick[rut_pkg::CS_DIV512]  <= tap(presc, rut_pkg::DIV512_LOG);
            src_tick[rut_pkg::CS_DIV64]   <= tap(presc, rut_pkg::DIV64_LOG);
            src_tick[rut_pkg::CS_DIV16]   <= tap(presc, rut_pkg::DIV16_LOG);
            src_tick[rut_pkg::CS_DIV4]    <= tap(presc, rut_pkg::DIV4_LOG);
            src_tick[rut_pkg::CS_SUB4]    <= sub_rise && (&sub_div);
            src_tick[rut_pkg::CS_EVENT]   <= evt_edge;
        end
    end
endmodule : rut_tick_gen
`default_nettype wire

// ---- design/rut_timer.sv ----
/*
 * reloadable 8-bit up/down timer with ahb-lite register slave.
 * assumes a single ahb-lite master, single word transfers, core_clk at 200 MHz.
 */
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rut_timer (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic        subclk,
    input  wire logic        event_input_pin,
    input  wire logic        count_direction_pin,
    // interrupt request to the cpu
    output logic             timer_irq
);
    logic [7:0] timer_mode;
    logic [7:0] timer_count;
    logic [7:0] timer_reload;
    logic [7:0] module_clock_stop;
    logic       timer_irq_flag;
    logic       timer_irq_enable;
    logic       line1_edge_select;

    // bus data-phase capture
    logic       wr_pend;
    logic [3:0] wr_ofs;

    logic [7:0] src_tick;
    logic [1:0] dir_sync;

    rut_tick_gen u_ticks (
        .core_clk          (core_clk),
        .rst               (rst),
        .subclk            (subclk),
        .event_input_pin   (event_input_pin),
        .line1_edge_select (line1_edge_select),
        .src_tick          (src_tick)
    );

    function automatic logic [7:0] mode_view(input logic [7:0] m);
        return m | rut_pkg::MODE_RSVD_MASK;
    endfunction : mode_view

    // address phase decode
    logic       addr_valid;
    logic [3:0] addr_ofs;
    assign addr_valid = hsel && hready && htrans[1];
    assign addr_ofs   = haddr[3:0];

    // data phase write strobes
    logic wr_mode;
    logic wr_reload;
    logic wr_stop;
    logic wr_irq;
    assign wr_mode   = wr_pend && (wr_ofs == rut_pkg::OFS_MODE);
    assign wr_reload = wr_pend && (wr_ofs == rut_pkg::OFS_COUNT);
    assign wr_stop   = wr_pend && (wr_ofs == rut_pkg::OFS_STOP);
    assign wr_irq    = wr_pend && (wr_ofs == rut_pkg::OFS_IRQ);

    // zero wait state, always okay
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_ofs  <= 4'h0;
        end else begin
            wr_pend <= addr_valid && hwrite;
            wr_ofs  <= addr_ofs;
        end
    end

    // read data is sampled at the address edge; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            unique case (addr_ofs)
                rut_pkg::OFS_MODE:  hrdata <= {24'h000000, mode_view(timer_mode)};
                rut_pkg::OFS_COUNT: hrdata <= {24'h000000, timer_count};
                rut_pkg::OFS_STOP:  hrdata <= {24'h000000, module_clock_stop};
                rut_pkg::OFS_IRQ:   hrdata <= {29'h00000000, line1_edge_select,
                                               timer_irq_enable, timer_irq_flag};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_mode <= rut_pkg::MODE_RESET;
        end else if (wr_mode) begin
            timer_mode <= mode_view(hwdata[7:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            module_clock_stop <= rut_pkg::STOP_RESET;
        end else if (wr_stop) begin
            module_clock_stop <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_reload <= rut_pkg::RELOAD_RESET;
        end else if (wr_reload) begin
            timer_reload <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_irq_enable  <= 1'b0;
            line1_edge_select <= 1'b0;
        end else if (wr_irq) begin
            timer_irq_enable  <= hwdata[rut_pkg::IRQ_EN_BIT];
            line1_edge_select <= hwdata[rut_pkg::IRQ_EDGE_BIT];
        end
    end

    // direction pin: two-flop synchroniser, only stage two is used
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_sync <= 2'h0;
        end else begin
            dir_sync <= {dir_sync[0], count_direction_pin};
        end
    end

    logic running;
    logic tick;
    logic count_up;
    logic wrap_up;
    logic wrap_down;
    logic wrap;
    assign running   = module_clock_stop[rut_pkg::STOP_TIMER_BIT];
    assign tick      = running && src_tick[timer_mode[2:0]];
    assign count_up  = timer_mode[rut_pkg::MODE_HWDIR_BIT] ? dir_sync[1]
                     : !timer_mode[rut_pkg::MODE_SWDIR_BIT];
    assign wrap_up   = tick && count_up && (timer_count == rut_pkg::COUNT_MAX);
    assign wrap_down = tick && !count_up && (timer_count == rut_pkg::COUNT_MIN);
    assign wrap      = wrap_up || wrap_down;

    logic [7:0] next_count;
    always_comb begin
        next_count = timer_count;
        if (wr_reload) begin
            next_count = hwdata[7:0];
        end else if (wrap && timer_mode[rut_pkg::MODE_RELOAD_BIT]) begin
            next_count = timer_reload;
        end else if (tick) begin
            // natural 8-bit wrap gives FF->00 and 00->FF in interval mode
            next_count = count_up ? timer_count + 8'h01 : timer_count - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_count <= rut_pkg::COUNT_RESET;
        end else begin
            timer_count <= next_count;
        end
    end

    // a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_irq_flag <= 1'b0;
        end else if (wrap) begin
            timer_irq_flag <= 1'b1;
        end else if (wr_irq && !hwdata[rut_pkg::IRQ_FLAG_BIT]) begin
            timer_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_irq_flag && timer_irq_enable;
        end
    end

    // checks
    property p_rsvd_read;
        @(posedge core_clk) disable iff (rst)
        addr_valid && !hwrite && addr_ofs == rut_pkg::OFS_MODE |=> hrdata[4:3] == 2'b11;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved mode bits not one");

    property p_reset_vals;
        @(posedge core_clk)
        rst |=> timer_mode == 8'h18 && timer_count == 8'h00 && timer_reload == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_load_write;
        @(posedge core_clk) disable iff (rst)
        wr_reload |=> timer_count == $past(hwdata[7:0]) && timer_reload == timer_count;
    endproperty
    a_load_write: assert property (p_load_write) else $error("reload write not loaded");

    property p_wrap_interval;
        @(posedge core_clk) disable iff (rst)
        wrap && !wr_reload && !timer_mode[7] |=>
            timer_count == ($past(count_up) ? 8'h00 : 8'hFF);
    endproperty
    a_wrap_interval: assert property (p_wrap_interval) else $error("interval wrap wrong");

    property p_wrap_reload;
        @(posedge core_clk) disable iff (rst)
        wrap && !wr_reload && timer_mode[7] |=> timer_count == $past(timer_reload);
    endproperty
    a_wrap_reload: assert property (p_wrap_reload) else $error("auto-reload missed");

    property p_flag_set;
        @(posedge core_clk) disable iff (rst)
        wrap |=> timer_irq_flag ##1 (timer_irq == $past(timer_irq_enable));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag or request missing");

    property p_irq_gate;
        @(posedge core_clk) disable iff (rst)
        !timer_irq_enable |=> !timer_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

    property p_standby;
        @(posedge core_clk) disable iff (rst)
        !module_clock_stop[1] && !wr_reload |=> $stable(timer_count);
    endproperty
    a_standby: assert property (p_standby) else $error("counted in standby");

    property p_hw_dir;
        @(posedge core_clk) disable iff (rst)
        tick && !wrap && !wr_reload && timer_mode[6] && dir_sync[1] |=>
            timer_count == $past(timer_count) + 8'h01;
    endproperty
    a_hw_dir: assert property (p_hw_dir) else $error("pin high did not count up");

    property p_sw_down;
        @(posedge core_clk) disable iff (rst)
        tick && !wrap && !wr_reload && timer_mode[6:5] == 2'b01 |=>
            timer_count == $past(timer_count) - 8'h01;
    endproperty
    a_sw_down: assert property (p_sw_down) else $error("software down failed");

    property p_count_hold;
        @(posedge core_clk) disable iff (rst)
        !tick && !wr_reload |=> $stable(timer_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved, no tick");

    property p_sw_up;
        @(posedge core_clk) disable iff (rst)
        tick && !wrap && !wr_reload && timer_mode[6:5] == 2'b00 |=>
            timer_count == $past(timer_count) + 8'h01;
    endproperty
    a_sw_up: assert property (p_sw_up) else $error("software up failed");

    property p_hw_down;
        @(posedge core_clk) disable iff (rst)
        tick && !wrap && !wr_reload && timer_mode[6] && !dir_sync[1] |=>
            timer_count == $past(timer_count) - 8'h01;
    endproperty
    a_hw_down: assert property (p_hw_down) else $error("pin low did not count down");

    property p_flag_hold;
        @(posedge core_clk) disable iff (rst)
        timer_irq_flag && !wr_irq |=> timer_irq_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_flag_clear;
        @(posedge core_clk) disable iff (rst)
        wr_irq && !hwdata[rut_pkg::IRQ_FLAG_BIT] && !wrap |=> !timer_irq_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_irq_raise;
        @(posedge core_clk) disable iff (rst)
        timer_irq_flag && timer_irq_enable |=> timer_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("request not raised");

    property p_irq_drop;
        @(posedge core_clk) disable iff (rst)
        !timer_irq_flag |=> !timer_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("request without flag");

    property p_reload_hold;
        @(posedge core_clk) disable iff (rst)
        !wr_reload |=> $stable(timer_reload);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload value moved");

    property p_mode_write;
        @(posedge core_clk) disable iff (rst)
        wr_mode |=> timer_mode == ($past(hwdata[7:0]) | rut_pkg::MODE_RSVD_MASK);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_rsvd_state;
        @(posedge core_clk) disable iff (rst)
        timer_mode[4:3] == 2'b11;
    endproperty
    a_rsvd_state: assert property (p_rsvd_state) else $error("reserved bits cleared");

    property p_sub_tick;
        @(posedge core_clk) disable iff (rst)
        src_tick[rut_pkg::CS_SUB4] |=> !src_tick[rut_pkg::CS_SUB4];
    endproperty
    a_sub_tick: assert property (p_sub_tick) else $error("subclock ticked twice");

    property p_div4_period;
        @(posedge core_clk) disable iff (rst)
        src_tick[rut_pkg::CS_DIV4] |-> ##4 src_tick[rut_pkg::CS_DIV4];
    endproperty
    a_div4_period: assert property (p_div4_period) else $error("div4 period wrong");

    property p_div16_period;
        @(posedge core_clk) disable iff (rst)
        src_tick[rut_pkg::CS_DIV16] |-> ##16 src_tick[rut_pkg::CS_DIV16];
    endproperty
    a_div16_period: assert property (p_div16_period) else $error("div16 period wrong");
endmodule : rut_timer
`default_nettype wire

// ---- testbench/reloadable_updown_timer8_tb_top.sv ----
/*
 * self-checking bench of the timer: ahb-lite master tasks and register-level tests.
 * assumes rut_pkg, rut_timer and rut_pin_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module reloadable_updown_timer8_tb_top;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic        timer_irq;
    logic        subclk;
    logic        event_input_pin;
    logic        count_direction_pin;
    logic [31:0] rd;
    int          mismatches;
    int          checked;
    int          dv[7] = '{8192, 2048, 512, 64, 16, 4, 32};

    rut_timer dut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .subclk(subclk),
        .event_input_pin(event_input_pin), .count_direction_pin(count_direction_pin),
        .timer_irq(timer_irq)
    );

    rut_pin_model pins (
        .core_clk(core_clk), .subclk(subclk), .event_input_pin(event_input_pin),
        .count_direction_pin(count_direction_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // address phase held until hready, then data phase held until hready again
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] wd,
                       output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {28'h0000000, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] g);
        checked++;
        if ($isunknown(g) || g < lo || g > hi) begin
            mismatches++;
            $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(nm, {24'h000000, e}, r);
    endtask : rdc

    // load, count events, read the counter back exactly
    task automatic ev(input logic [7:0] mode, input logic [7:0] ld, input int n,
                      input logic [7:0] e);
        wr(rut_pkg::OFS_MODE, mode);
        wr(rut_pkg::OFS_COUNT, ld);
        pins.pulse(n);
        rdc(rut_pkg::OFS_COUNT, e, "count");
    endtask : ev

    initial begin
        repeat (80000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'h2;
        mismatches = 0;
        checked = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(rut_pkg::OFS_MODE, 8'h18, "mode reset");
        rdc(rut_pkg::OFS_COUNT, 8'h00, "count reset");
        rdc(rut_pkg::OFS_STOP, 8'hFF, "stop reset");
        rdc(rut_pkg::OFS_IRQ, 8'h00, "irq reset");
        chk("hresp", 32'h0, {31'h0, hresp});
        wr(rut_pkg::OFS_MODE, 8'h00);
        rdc(rut_pkg::OFS_MODE, 8'h18, "mode reserved");
        wr(rut_pkg::OFS_MODE, 8'hE7);
        rdc(rut_pkg::OFS_MODE, 8'hFF, "mode all");
        // select codes 0 to 6 each tick two or three times in two of their periods
        for (int c = 0; c < 7; c++) begin
            wr(rut_pkg::OFS_MODE, {5'h03, c[2:0]});
            wr(rut_pkg::OFS_COUNT, 8'h00);
            repeat (2 * dv[c]) @(posedge core_clk);
            bus(1'b0, rut_pkg::OFS_COUNT, 8'h00, rd);
            chk_rng("rate", 2, 3, rd[7:0]);
        end
        // edge select and irq enable set before the event code is chosen
        wr(rut_pkg::OFS_IRQ, 8'h06);
        ev(8'h87, 8'hFE, 3, 8'hFF);
        rdc(rut_pkg::OFS_IRQ, 8'h07, "flag up");
        chk("irq on", 32'h1, {31'h0, timer_irq});
        wr(rut_pkg::OFS_IRQ, 8'h04);
        repeat (3) @(posedge core_clk);
        chk("irq off", 32'h0, {31'h0, timer_irq});
        ev(8'hA7, 8'h01, 3, 8'h00);
        rdc(rut_pkg::OFS_IRQ, 8'h05, "flag down");
        chk("irq masked", 32'h0, {31'h0, timer_irq});
        wr(rut_pkg::OFS_IRQ, 8'h04);
        ev(8'h07, 8'hFE, 3, 8'h01);
        ev(8'h27, 8'h01, 3, 8'hFE);
        pins.set_dir(1'b0);
        ev(8'h67, 8'h10, 2, 8'h0E);
        pins.set_dir(1'b1);
        ev(8'h47, 8'h10, 2, 8'h12);
        wr(rut_pkg::OFS_IRQ, 8'h00);
        ev(8'h07, 8'h20, 2, 8'h22);
        // standby: counting stops but the reload path still loads
        wr(rut_pkg::OFS_STOP, 8'hFD);
        rdc(rut_pkg::OFS_STOP, 8'hFD, "stop");
        wr(rut_pkg::OFS_MODE, 8'h05);
        wr(rut_pkg::OFS_COUNT, 8'h33);
        repeat (40) @(posedge core_clk);
        rdc(rut_pkg::OFS_COUNT, 8'h33, "standby");
        wr(rut_pkg::OFS_STOP, 8'hFF);
        repeat (40) @(posedge core_clk);
        bus(1'b0, rut_pkg::OFS_COUNT, 8'h00, rd);
        chk_rng("resume", 8'h3A, 8'h3F, rd[7:0]);
        tally_and_finish();
    end
endmodule : reloadable_updown_timer8_tb_top
`default_nettype wire

// ---- testbench/rut_pin_model.sv ----
/*
 * pin-side partner of the timer: free-running subclock, event pulses, direction level.
 * assumes the port function bits of both pins were set by software beforehand.
 */
`timescale 1ns/1ps
`default_nettype none
module rut_pin_model (
    // clock
    input  wire logic core_clk,
    // pins toward the timer
    output logic      subclk,
    output logic      event_input_pin,
    output logic      count_direction_pin
);
    // subclock toggles every four core_clk edges: one sub/4 tick per 32 cycles
    initial begin
        subclk = 1'b0;
        forever begin
            repeat (4) @(posedge core_clk);
            subclk <= ~subclk;
        end
    end

    initial begin
        event_input_pin = 1'b0;
        count_direction_pin = 1'b1;
    end

    // event pin is routed to the timer, line 1 interrupt left disabled
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            event_input_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        // synchronizer and edge detect need a few cycles to land
        repeat (8) @(posedge core_clk);
    endtask : pulse

    // direction pin function enabled before hardware direction is used
    task automatic set_dir(input logic v);
        @(posedge core_clk);
        count_direction_pin <= v;
        repeat (4) @(posedge core_clk);
    endtask : set_dir
endmodule : rut_pin_model
`default_nettype wire
